// ---- inertial_sensor_scaling_config_regs_tb.sv ----
// self-checking bench of the scaling/config register bank
`timescale 1ns/1ps
`default_nettype none
module inertial_sensor_scaling_config_regs_tb;
  localparam logic [15:0] MAX_DPS10 = 16'h0dac;  // sensor cap, 350.0
  // clock, reset, link and data path signals
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic spi_sclk, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [15:0] rate_mag_dps10 = 16'h0000;
  logic [15:0] accel_mag_mg = 16'h0000;
  logic [7:0] smoothing_filter;
  isscr_pkg::isscr_scale_t spi_scale;
  logic [15:0] axis_orient;
  logic over_range, nv_save;
  logic [4:0] nv_save_sel;
  int fails = 0, n_compared = 0, n_saves = 0;
  // reference model state and range tables
  int m_ri = 1, m_flt = 6, m_ai = 3, m_ori = 0;
  int rs[5] = '{400, 200, 100, 50, 25};
  int rl[5] = '{800, 1600, 2000, 4000, 6000};
  int ro[5] = '{625, 1250, 2200, 4400, 6600};
  int as[5] = '{32768, 16384, 8192, 4000, 4096};
  int ao[5] = '{900, 1800, 3600, 4500, 7200};
  // system clock
  always #5 clk_sys = ~clk_sys;
  // count save pulses
  always @(posedge clk_sys) begin
    if (nv_save === 1'b1) n_saves++;
  end
  isscr_regs #(.SENSOR_MAX_DPS10(MAX_DPS10)) i_isscr_regs (
    .clk_sys(clk_sys), .resetn(resetn), .spi_sclk(spi_sclk),
    .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .rate_mag_dps10(rate_mag_dps10),
    .accel_mag_mg(accel_mag_mg), .smoothing_filter(smoothing_filter),
    .spi_scale(spi_scale), .axis_orient(axis_orient),
    .over_range(over_range), .nv_save(nv_save), .nv_save_sel(nv_save_sel));
  isscr_spi_master i_isscr_spi_master (
    .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  // compare and count
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one frame launched just after a system edge
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    logic oe;
    @(posedge clk_sys);
    #1;
    i_isscr_spi_master.xfer(w, r, oe);
    check(80'(oe), 80'h1);
    check(80'(spi_miso_oe), 80'h0);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    frame({1'b1, a, d}, r);
  endtask
  // read answer arrives in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    frame({1'b0, a, 8'($urandom)}, d);
    frame({1'b0, 7'h10, 8'h00}, d);
  endtask
  task automatic rdc(input logic [6:0] a, input int exp);
    logic [15:0] d;
    rd(a, d);
    check(80'(d), 80'(exp[15:0]));
  endtask
  // expected figures from the model
  function automatic logic [79:0] exp_scale();
    int lim;
    lim = (rl[m_ri] > int'(MAX_DPS10)) ? int'(MAX_DPS10) : rl[m_ri];
    return {16'(rs[m_ri]), 16'(lim), 16'(ro[m_ri]), 16'(as[m_ai]),
            16'(ao[m_ai])};
  endfunction
  task automatic check_state();
    check(80'(spi_scale), exp_scale());
    check(80'(smoothing_filter), 80'(m_flt));
    check(80'(axis_orient), 80'(m_ori));
    rdc(7'h38, ((1 << m_ri) << 8) | m_flt);
    rdc(7'h70, (m_ri << 12) | (m_ai << 4) | 'h0f0f);
  endtask
  // magnitudes in, over-range flag out
  task automatic ovr(input int r, input int a, input int exp);
    @(posedge clk_sys);
    #1;
    rate_mag_dps10 = 16'(r);
    accel_mag_mg = 16'(a);
    repeat (3) @(posedge clk_sys);
    #1;
    check(80'(over_range), 80'(exp));
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #800000;
    fails++;
    print_verdict();
  end
  // main sequence
  initial begin : main
    logic [15:0] d;
    int fc[9] = '{3, 4, 5, 6, 'h30, 'h50, 'h60, 0, 'h40};
    int sc[7] = '{0, 'h74, 'h38, 'h35, 'h36, 'h39, 'h12};
    int ss[7] = '{'h1f, 1, 2, 4, 8, 'h10, 'h10};
    int k;
    void'($urandom(32'h7dfe1818));
    repeat (12) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    check_state();
    rdc(7'h7e, 0);
    rdc(7'h40, 0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(7'h39, 8'(1 << i));
      m_ri = i;
      check_state();
    end
    wr(7'h39, 8'h03);
    check_state();
    $display("test rate range done");
    foreach (fc[i]) begin
      wr(7'h38, 8'(fc[i]));
      m_flt = fc[i];
      check(80'(smoothing_filter), 80'(m_flt));
    end
    wr(7'h38, 8'h07);
    check_state();
    $display("test filter done");
    for (int i = 0; i < 5; i++) begin
      wr(7'h71, 8'(i << 4));
      wr(7'h70, 8'((4 - i) << 4));
      m_ri = i;
      m_ai = 4 - i;
      check_state();
      ovr(ro[m_ri] + 1, $urandom % (ao[m_ai] + 1), 1);
      ovr(ro[m_ri], ao[m_ai], 0);
      ovr($urandom % (ro[m_ri] + 1), ao[m_ai] + 1, 1);
    end
    wr(7'h70, 8'h50);
    check_state();
    $display("test scaling done");
    wr(7'h75, 8'h11);
    check(80'(axis_orient), 80'(m_ori));
    wr(7'h74, 8'h01);
    wr(7'h75, 8'h11);
    m_ori = 'h0111;
    rdc(7'h74, m_ori);
    wr(7'h74, 8'h00);
    rd(7'h74, d);
    wr(7'h75, 8'h00);
    check(80'(axis_orient), 80'(m_ori));
    wr(7'h74, 8'h00);
    wr(7'h75, 8'h10);
    check(80'(axis_orient), 80'(m_ori));
    wr(7'h74, 8'h00);
    wr(7'h38, 8'h40);
    wr(7'h75, 8'h00);
    check(80'(axis_orient), 80'(m_ori));
    wr(7'h74, 8'h00);
    wr(7'h75, 8'h00);
    m_ori = 0;
    check(80'(axis_orient), 80'(m_ori));
    $display("test orientation done");
    foreach (sc[i]) begin
      k = n_saves;
      wr(7'h76, 8'(sc[i]));
      check(80'(n_saves - k), 80'(i < 6));
      check(80'(nv_save_sel), 80'(ss[i]));
    end
    $display("test save done");
    wr(7'h7e, 8'h5a);
    rdc(7'h7e, 0);
    $display("test version done");
    print_verdict();
  end
endmodule  // inertial_sensor_scaling_config_regs_tb
`default_nettype wire

// ---- isscr_pkg.sv ----
// shared constants and carriers of the scaling/config register bank
package isscr_pkg;
  // register locations (write byte addresses and read word addresses)
  localparam logic [6:0] ADDR_FILT = 7'h38;
  localparam logic [6:0] ADDR_RATE = 7'h39;
  localparam logic [6:0] ADDR_ACCEL = 7'h70;
  localparam logic [6:0] ADDR_ALT_RATE = 7'h71;
  localparam logic [6:0] ADDR_ORIENT_HI = 7'h74;
  localparam logic [6:0] ADDR_ORIENT_LO = 7'h75;
  localparam logic [6:0] ADDR_SAVE = 7'h76;
  localparam logic [6:0] ADDR_VERSION = 7'h7e;
  localparam logic [6:0] ADDR_DRDY = 7'h35;
  localparam logic [6:0] ADDR_ODR = 7'h36;
  // reset values
  localparam logic [15:0] RST_RATE_FILT = 16'h0206;
  localparam logic [15:0] RST_SCALING = 16'h1f3f;
  localparam logic [15:0] RST_ORIENT = 16'h0000;
  localparam logic [2:0] RST_RATE_IDX = 3'h1;
  localparam logic [2:0] RST_ACCEL_IDX = 3'h3;
  localparam logic [2:0] MAX_RANGE_IDX = 3'h4;
  // scaling register field positions and reserved fill
  localparam int SCL_RATE_LSB = 12;
  localparam int SCL_ACCEL_LSB = 4;
  localparam logic [15:0] SCL_RSVD_MASK = 16'h0f0f;
  // orientation fields: signs [10:8], axis permutation [6:4]
  localparam int ORI_SIGN_LSB = 8;
  localparam int ORI_PERM_LSB = 4;
  // save selectors and their bit in the save select output
  localparam logic [7:0] SAVE_ALL = 8'h00;
  localparam int SV_ORIENT = 0;
  localparam int SV_RANGE = 1;
  localparam int SV_DRDY = 2;
  localparam int SV_ODR = 3;
  localparam int SV_FILT = 4;
  // spi word layout
  localparam int SPI_BITS = 16;
  localparam int WR_BIT = 15;
  // link-side state
  typedef struct packed {
    logic [3:0] cnt;   // bit position in word
    logic [15:0] sh;   // receive shifter
    logic [15:0] tx;   // transmit shifter
    logic [15:0] rx;   // last whole word
    logic tg;          // flips per whole word
  } isscr_link_t;
  // system-side state
  typedef struct packed {
    logic [2:0] sync;       // toggle synchroniser and edge stage
    logic [2:0] rate_idx;   // rate range 0..4
    logic [7:0] filt;       // smoothing_filter code
    logic [2:0] accel_idx;  // accel range 0..4
    logic [15:0] orient;    // active orientation
    logic [7:0] ori_hi;     // held high byte
    logic pend;             // high byte written, low awaited
    logic save;             // save strobe
    logic [4:0] save_sel;   // settings to save
    logic [15:0] rd_word;   // answer for next frame
    logic over_range;       // sensor over-range flag
  } isscr_sys_t;
  // range dependent figures for the spi data path
  typedef struct packed {
    logic [15:0] rate_scale;   // lsb per deg/s
    logic [15:0] rate_limit;   // signal limit, 0.1 deg/s
    logic [15:0] rate_ovr;     // over-range limit, 0.1 deg/s
    logic [15:0] accel_range_byte;  // lsb per g
    logic [15:0] accel_ovr;    // over-range limit, mg
  } isscr_scale_t;
endpackage

// ---- isscr_regs.sv ----
// spi mode 3 register bank for rate/accel scaling, filter, orientation, save
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 16-bit range/filter register, reset 0x0206
// - upper byte one-hot rate range code
// - lower byte selects smoothing filter code
// - settings affect spi data path only
// - range scales rate registers and standard packet
// - rate scale 400/200/100/50/25 lsb per dps
// - rate limit per range, capped by sensor
// - over-range flag above per-range rate or accel over-range limit
// - range mirrored between 0x38 and 0x71
// - scaling register 0x70, reset 0x1f3f
// - bits 7:4 accel range, default 5 g
// - accel_range_byte factors and over-range limits
// - low byte ignored without prior high byte
// - reading 0x74 cancels pending orientation write
// - right-handed orientation only, default +x+y+z
// - save code 0x00 saves all settings
// - single code saves only that setting
// - read-only version register at 0x7e
// - spi mode 3, 16-bit words, msb first
module isscr_regs #(
  parameter logic [7:0] HW_VERSION = 8'h00,  // arbitrary value
  parameter logic [7:0] SW_VERSION = 8'h00,  // arbitrary value
  parameter logic [15:0] SENSOR_MAX_DPS10 = 16'h1770  // 600.0 deg/s
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // spi link, mode 3
  input wire logic spi_sclk,
  input wire logic spi_ss_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // sensor magnitudes from the data path
  input wire logic [15:0] rate_mag_dps10,
  input wire logic [15:0] accel_mag_mg,
  // settings for the spi data path
  output logic [7:0] smoothing_filter,
  output isscr_pkg::isscr_scale_t spi_scale,
  output logic [15:0] axis_orient,
  output logic over_range,
  // non-volatile save request
  output logic nv_save,
  output logic [4:0] nv_save_sel
);

  // per-range figures, index 0..4
  function automatic isscr_pkg::isscr_scale_t scale_of(
      input logic [2:0] r, input logic [2:0] a);
    isscr_pkg::isscr_scale_t f;
    f = '0;
    unique case (r)
      3'h0: f[79:32] = {16'd400, 16'd800, 16'd625};
      3'h1: f[79:32] = {16'd200, 16'd1600, 16'd1250};
      3'h2: f[79:32] = {16'd100, 16'd2000, 16'd2200};
      3'h3: f[79:32] = {16'd50, 16'd4000, 16'd4400};
      default: f[79:32] = {16'd25, 16'd6000, 16'd6600};
    endcase
    unique case (a)
      3'h0: f[31:0] = {16'd32768, 16'd900};
      3'h1: f[31:0] = {16'd16384, 16'd1800};
      3'h2: f[31:0] = {16'd8192, 16'd3600};
      3'h3: f[31:0] = {16'd4000, 16'd4500};
      default: f[31:0] = {16'd4096, 16'd7200};
    endcase
    return f;
  endfunction

  // legal smoothing filter code
  function automatic logic filt_ok(input logic [7:0] c);
    unique case (c)
      8'h00, 8'h03, 8'h04, 8'h05, 8'h06: return 1'b1;
      8'h30, 8'h40, 8'h50, 8'h60: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // right-handed check: permutation parity against sign parity
  function automatic logic orient_ok(input logic [15:0] w);
    logic [2:0] p;
    logic odd;
    p = w[isscr_pkg::ORI_PERM_LSB +: 3];
    odd = (p == 3'h1) || (p == 3'h3) || (p == 3'h5);
    return (p <= 3'h5) &&
      ((^w[isscr_pkg::ORI_SIGN_LSB +: 3]) == odd);
  endfunction

  // one-hot rate byte to range index, bit 3 flags a bad code
  function automatic logic [3:0] rate_idx_of(input logic [7:0] b);
    unique case (b)
      8'h01: return 4'h0;
      8'h02: return 4'h1;
      8'h04: return 4'h2;
      8'h08: return 4'h3;
      8'h10: return 4'h4;
      default: return 4'h8;
    endcase
  endfunction

  // link domain state and next value
  isscr_pkg::isscr_link_t l;
  isscr_pkg::isscr_link_t next_l;
  // system domain state and next value
  isscr_pkg::isscr_sys_t s;
  isscr_pkg::isscr_sys_t next_s;
  // decoded word from the link
  logic word_evt;
  logic [15:0] w;
  logic is_wr;
  logic [6:0] addr;
  logic [3:0] rate_dec;
  logic [7:0] rate_onehot;
  logic [15:0] scaling_rd;

  // link side: sample on rising edge, msb first, 16-bit words
  always_comb begin
    next_l = l;
    if (!spi_ss_n) begin
      next_l.cnt = l.cnt + 4'h1;
      next_l.sh = {l.sh[14:0], spi_mosi};
      // first edge loads answer; it stood stable since last word
      next_l.tx = (l.cnt == 4'h0) ? {s.rd_word[14:0], 1'b0}
                                  : {l.tx[14:0], 1'b0};
      if (l.cnt == 4'(isscr_pkg::SPI_BITS - 1)) begin
        next_l.rx = {l.sh[14:0], spi_mosi};
        next_l.tg = ~l.tg;
      end
    end
  end

  // link registers run on the link's own clock
  always_ff @(posedge spi_sclk or negedge resetn) begin
    if (!resetn) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // first bit before first edge, then shifter msb
  assign spi_miso = (l.cnt == 4'h0) ? s.rd_word[15] : l.tx[15];
  assign spi_miso_oe = !spi_ss_n;

  // word decode; rx is stable well before the synced toggle lands
  assign word_evt = s.sync[2] ^ s.sync[1];
  assign w = l.rx;
  assign is_wr = w[isscr_pkg::WR_BIT];
  assign addr = w[14:8];
  assign rate_dec = rate_idx_of(w[7:0]);
  assign rate_onehot = 8'h01 << s.rate_idx;
  // reserved nibbles read as their reset fill
  assign scaling_rd = isscr_pkg::SCL_RSVD_MASK |
    (16'(s.rate_idx) << isscr_pkg::SCL_RATE_LSB) |
    (16'(s.accel_idx) << isscr_pkg::SCL_ACCEL_LSB);

  // system side: register writes, reads and save requests
  always_comb begin
    next_s = s;
    next_s.save = 1'b0;
    next_s.sync = {s.sync[1:0], l.tg};
    next_s.over_range = (rate_mag_dps10 > spi_scale.rate_ovr) ||
      (accel_mag_mg > spi_scale.accel_ovr);
    if (word_evt && is_wr) begin
      // any write other than the orientation pair breaks the pair
      next_s.pend = 1'b0;
      unique case (addr)
        isscr_pkg::ADDR_RATE: begin
          if (!rate_dec[3]) begin
            next_s.rate_idx = rate_dec[2:0];
          end
        end
        isscr_pkg::ADDR_FILT: begin
          if (filt_ok(w[7:0])) begin
            next_s.filt = w[7:0];
          end
        end
        isscr_pkg::ADDR_ALT_RATE: begin
          if (w[7:4] <= 4'(isscr_pkg::MAX_RANGE_IDX)) begin
            next_s.rate_idx = w[6:4];
          end
        end
        isscr_pkg::ADDR_ACCEL: begin
          if (w[7:4] <= 4'(isscr_pkg::MAX_RANGE_IDX)) begin
            next_s.accel_idx = w[6:4];
          end
        end
        isscr_pkg::ADDR_ORIENT_HI: begin
          next_s.ori_hi = w[7:0];
          next_s.pend = 1'b1;
        end
        isscr_pkg::ADDR_ORIENT_LO: begin
          // bytes load as sent, no swap
          if (s.pend && orient_ok({s.ori_hi, w[7:0]})) begin
            next_s.orient = {s.ori_hi, w[7:0]};
          end
        end
        isscr_pkg::ADDR_SAVE: begin
          next_s.save = 1'b1;
          unique case (w[7:0])
            isscr_pkg::SAVE_ALL: next_s.save_sel = 5'h1f;
            {1'b0, isscr_pkg::ADDR_ORIENT_HI}:
              next_s.save_sel = 5'h01 << isscr_pkg::SV_ORIENT;
            {1'b0, isscr_pkg::ADDR_FILT}:
              next_s.save_sel = 5'h01 << isscr_pkg::SV_RANGE;
            {1'b0, isscr_pkg::ADDR_DRDY}:
              next_s.save_sel = 5'h01 << isscr_pkg::SV_DRDY;
            {1'b0, isscr_pkg::ADDR_ODR}:
              next_s.save_sel = 5'h01 << isscr_pkg::SV_ODR;
            {1'b0, isscr_pkg::ADDR_RATE}:
              next_s.save_sel = 5'h01 << isscr_pkg::SV_FILT;
            default: next_s.save = 1'b0;
          endcase
        end
        default: begin
          next_s.pend = 1'b0;
        end
      endcase
    end else if (word_evt) begin
      // read: answer goes out in the next frame
      unique case (addr)
        isscr_pkg::ADDR_FILT: next_s.rd_word = {rate_onehot, s.filt};
        isscr_pkg::ADDR_ACCEL: next_s.rd_word = scaling_rd;
        isscr_pkg::ADDR_ORIENT_HI: begin
          next_s.rd_word = s.orient;
          next_s.pend = 1'b0;
        end
        isscr_pkg::ADDR_VERSION:
          next_s.rd_word = {HW_VERSION, SW_VERSION};
        default: next_s.rd_word = 16'h0000;
      endcase
    end
  end

  // system registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.rate_idx <= isscr_pkg::RST_RATE_IDX;
      s.filt <= isscr_pkg::RST_RATE_FILT[7:0];
      s.accel_idx <= isscr_pkg::RST_ACCEL_IDX;
      s.orient <= isscr_pkg::RST_ORIENT;
    end else begin
      s <= next_s;
    end
  end

  // spi path settings; uart path takes none of these
  always_comb begin
    spi_scale = scale_of(s.rate_idx, s.accel_idx);
    if (spi_scale.rate_limit > SENSOR_MAX_DPS10) begin
      spi_scale.rate_limit = SENSOR_MAX_DPS10;
    end
  end
  assign smoothing_filter = s.filt;
  assign axis_orient = s.orient;
  assign over_range = s.over_range;
  assign nv_save = s.save;
  assign nv_save_sel = s.save_sel;

  // read of 0x74 drops a pending pair
  property p_read_cancels;
    @(posedge clk_sys) disable iff (!resetn)
    word_evt && !is_wr && addr == isscr_pkg::ADDR_ORIENT_HI |=> !s.pend;
  endproperty
  a_read_cancels: assert property (p_read_cancels)
    else $error("orientation pair not cancelled by read");

  // low byte without high byte leaves orientation
  property p_lo_alone;
    @(posedge clk_sys) disable iff (!resetn)
    word_evt && is_wr && addr == isscr_pkg::ADDR_ORIENT_LO && !s.pend
      |=> $stable(s.orient);
  endproperty
  a_lo_alone: assert property (p_lo_alone)
    else $error("lone low byte changed orientation");

  // alternate rate write shows in the range byte
  property p_mirror;
    @(posedge clk_sys) disable iff (!resetn)
    word_evt && is_wr && addr == isscr_pkg::ADDR_ALT_RATE &&
      w[7:4] == 4'h3 |=> rate_onehot == 8'h08;
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("range not mirrored");

  // save all selects five settings for one cycle
  property p_save_all;
    @(posedge clk_sys) disable iff (!resetn)
    word_evt && is_wr && addr == isscr_pkg::ADDR_SAVE && w[7:0] == 8'h00
      |=> nv_save && nv_save_sel == 5'h1f ##1 !nv_save;
  endproperty
  a_save_all: assert property (p_save_all)
    else $error("save all malformed");

  // single save of range
  property p_save_one;
    @(posedge clk_sys) disable iff (!resetn)
    word_evt && is_wr && addr == isscr_pkg::ADDR_SAVE && w[7:0] == 8'h38
      |=> nv_save && nv_save_sel == 5'h02;
  endproperty
  a_save_one: assert property (p_save_one)
    else $error("single save wrong");

  // bad filter code ignored
  property p_filt_bad;
    @(posedge clk_sys) disable iff (!resetn)
    word_evt && is_wr && addr == isscr_pkg::ADDR_FILT && !filt_ok(w[7:0])
      |=> $stable(smoothing_filter);
  endproperty
  a_filt_bad: assert property (p_filt_bad)
    else $error("illegal filter code taken");

  // scale follows range index
  property p_scale;
    @(posedge clk_sys) disable iff (!resetn)
    s.rate_idx == 3'h0 |-> spi_scale.rate_scale == 16'd400 &&
      spi_scale.rate_ovr == 16'd625;
  endproperty
  a_scale: assert property (p_scale)
    else $error("rate scale wrong");

  // over-range raised one cycle after excess motion
  property p_ovr;
    @(posedge clk_sys) disable iff (!resetn)
    rate_mag_dps10 > spi_scale.rate_ovr |=> over_range;
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("over-range not raised");

  // version read answers with fixed codes
  property p_version;
    @(posedge clk_sys) disable iff (!resetn)
    word_evt && !is_wr && addr == isscr_pkg::ADDR_VERSION
      |=> s.rd_word == {HW_VERSION, SW_VERSION};
  endproperty
  a_version: assert property (p_version)
    else $error("version answer wrong");

endmodule  // isscr_regs
`default_nettype wire

// ---- isscr_spi_master.sv ----
// spi mode 3 master model facing the register bank link
`timescale 1ns/1ps
`default_nettype none
module isscr_spi_master #(
  parameter int HALF_NS = 80  // half sclk period
) (
  // link to the bank
  output logic spi_sclk,
  output logic spi_ss_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  // idle: clock parked high, bank not selected
  initial begin
    spi_sclk = 1'b1;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // one whole 16-bit frame, msb first; miso taken before each rise
  task automatic xfer(input logic [15:0] w, output logic [15:0] r,
                      output logic oe);
    // random sub-period skew keeps sclk unrelated in phase to clk_sys
    #(($urandom % 89) * 0.1);
    spi_ss_n = 1'b0;
    #(HALF_NS);
    oe = spi_miso_oe;
    for (int i = 15; i >= 0; i--) begin
      spi_sclk = 1'b0;
      spi_mosi = w[i];
      #(HALF_NS);
      r[i] = spi_miso;
      spi_sclk = 1'b1;
      #(HALF_NS);
    end
    spi_ss_n = 1'b1;
    spi_mosi = ~w[0];  // released line shows no stale level
    #1200;  // frame gap lets the system side take the word
  endtask
endmodule  // isscr_spi_master
`default_nettype wire
